// [design/spc_speed_profile.sv]
// speed profile and protection control top
`timescale 1ns/1ps
`default_nettype none
module spc_speed_profile
    import spc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // operation inputs
    input  wire logic        data_select_bit0,
    input  wire logic        data_select_bit1,
    input  wire logic        run_in,
    input  wire logic        ext_stop_in,
    // dial edit port
    input  wire logic        edit_strobe,
    input  wire logic [1:0]  edit_field,
    input  wire logic [1:0]  edit_set,
    input  wire logic [12:0] edit_value,
    input  wire logic        init_strobe,
    input  wire logic        edit_lock,
    // parameters
    input  wire logic        ramp_digital,
    input  wire logic [7:0]  pot_time,
    input  wire logic        limit_strobe,
    input  wire logic [12:0] limit_upper,
    input  wire logic [12:0] limit_lower,
    input  wire logic        hold_enable,
    input  wire logic [7:0]  angle_dev,
    // protection
    input  wire logic        alarm_event,
    input  wire logic [7:0]  alarm_code_in,
    input  wire logic        warn_level,
    input  wire logic        alarm_reset,
    input  wire logic        other_screen,
    // outputs
    output var  logic [12:0] speed_ref,
    output var  logic        drive_enable,
    output var  logic [6:0]  hold_torque,
    output var  logic [7:0]  alarm_code,
    output var  logic        alarm_display_on,
    output var  logic        warning_out,
    output var  logic        lock_indicate,
    output var  logic        edit_rejected,
    output var  logic [1:0]  active_set
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sel0_sync, sel1_sync, run_sync, stop_sync;
    logic       sel0_reg, sel1_reg, run_reg, stop_reg;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sel0_sync <= 3'h0;
            sel1_sync <= 3'h0;
            run_sync  <= 3'h0;
            stop_sync <= 3'h0;
        end
        else
        begin
            sel0_sync <= {sel0_sync[1:0], data_select_bit0};
            sel1_sync <= {sel1_sync[1:0], data_select_bit1};
            run_sync  <= {run_sync[1:0],  run_in};
            stop_sync <= {stop_sync[1:0], ext_stop_in};
        end
    end

    // filtered levels
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sel0_reg <= 1'b0;
            sel1_reg <= 1'b0;
            run_reg  <= 1'b0;
            stop_reg <= 1'b0;
        end
        else
        begin
            if (sel0_sync[1] == sel0_sync[2]) sel0_reg <= sel0_sync[2];
            if (sel1_sync[1] == sel1_sync[2]) sel1_reg <= sel1_sync[2];
            if (run_sync[1] == run_sync[2])   run_reg  <= run_sync[2];
            if (stop_sync[1] == stop_sync[2]) stop_reg <= stop_sync[2];
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [12:0] clamp_speed(input logic [12:0] v,
                                                input logic [12:0] lo,
                                                input logic [12:0] hi);
        clamp_speed = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction

    function automatic logic [7:0] clamp_time(input logic [7:0] t);
        clamp_time = (t > SPC_TIME_MAX) ? SPC_TIME_MAX
                   : ((t < SPC_TIME_MIN) ? SPC_TIME_MIN : t);
    endfunction

    // step per tick: span spread over time*ticks_per_ds ticks, at least 1
    function automatic logic [12:0] ramp_step(input logic [12:0] span, input logic [7:0] t);
        logic [23:0] den;
        logic [23:0] q;
        den = 24'(clamp_time(t)) * 24'(SPC_TICKS_PER_DS);
        q   = (24'(span) << 8) / den;
        ramp_step = (q[23:8] == 16'h0) ? 13'h1 : 13'(q[20:8]);
    endfunction

    // ------------------------------------------------------------
    // limits and data memory
    // ------------------------------------------------------------
    logic [12:0] upper_reg, lower_reg;
    logic [1:0]  sweep_reg;
    logic        sweep_busy_reg;
    logic [28:0] rd_data, wr_data;
    logic        wr_en;
    logic [1:0]  wr_idx, rd_idx;
    logic        sweep_valid_reg;
    logic [1:0]  sweep_rd_reg;

    // speed limits, held within 50..4000
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            upper_reg <= SPC_SPEED_MAX;
            lower_reg <= SPC_SPEED_MIN;
        end
        else if (limit_strobe && !edit_lock && limit_lower <= limit_upper)
        begin
            upper_reg <= clamp_speed(limit_upper, SPC_SPEED_MIN, SPC_SPEED_MAX);
            lower_reg <= clamp_speed(limit_lower, SPC_SPEED_MIN, SPC_SPEED_MAX);
        end
    end

    // after a limit change, walk the four sets and pull speeds inside
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sweep_busy_reg  <= 1'b0;
            sweep_reg       <= 2'h0;
            sweep_valid_reg <= 1'b0;
            sweep_rd_reg    <= 2'h0;
        end
        else
        begin
            sweep_valid_reg <= sweep_busy_reg;
            sweep_rd_reg    <= sweep_reg;
            if (limit_strobe && !edit_lock)
            begin
                sweep_busy_reg <= 1'b1;
                sweep_reg      <= 2'h0;
            end
            else if (sweep_busy_reg)
            begin
                sweep_reg <= sweep_reg + 2'h1;
                if (sweep_reg == 2'h3)
                    sweep_busy_reg <= 1'b0;
            end
        end
    end

    // write mux: sweep overwrite, then initialization, then dial edit
    logic        edit_ok;
    logic [12:0] swept;
    always_comb
    begin
        swept   = clamp_speed(rd_data[28:16], lower_reg, upper_reg);
        edit_ok = edit_strobe && !edit_lock && !sweep_busy_reg && !sweep_valid_reg;
        wr_en   = 1'b0;
        wr_idx  = edit_set;
        wr_data = rd_data;
        if (sweep_valid_reg)
        begin
            wr_en   = 1'b1;
            wr_idx  = sweep_rd_reg;
            wr_data = {swept, rd_data[15:0]};
        end
        else if (init_strobe && !edit_lock && !sweep_busy_reg)
        begin
            wr_en   = 1'b1;
            wr_idx  = active_set;
            wr_data = {clamp_speed(SPC_SPEED_DEFAULT, lower_reg, upper_reg),
                       SPC_TIME_DIG_DEF, SPC_TIME_DIG_DEF};
        end
        else if (edit_ok && edit_field == 2'(SPC_FIELD_SPEED))
        begin
            wr_en   = (edit_value <= upper_reg) && (edit_value >= lower_reg);
            wr_data = {edit_value, rd_data[15:0]};
        end
        else if (edit_ok && edit_field == 2'(SPC_FIELD_ACC))
        begin
            wr_en   = 1'b1;
            wr_data = {rd_data[28:16], clamp_time(edit_value[7:0]), rd_data[7:0]};
        end
        else if (edit_ok && edit_field == 2'(SPC_FIELD_DEC))
        begin
            wr_en   = 1'b1;
            wr_data = {rd_data[28:8], clamp_time(edit_value[7:0])};
        end
    end

    // a sweep reads the swept set; edits read-modify-write the edited set; otherwise read the active set
    assign rd_idx = sweep_busy_reg ? sweep_reg : (edit_strobe ? edit_set : active_set);

    spc_data_mem u_mem (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (wr_en),
        .wr_idx  (wr_idx),
        .wr_data (wr_data),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    // ------------------------------------------------------------
    // lock indication and edit refusal
    // ------------------------------------------------------------
    logic [14:0] lock_cnt_reg;
    // the tick is declared here because the lock countdown reads it
    logic [14:0] tick_cnt_reg;
    logic        tick_reg;

    // a dial attempt under lock shows the indication for about a second
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lock_cnt_reg  <= 15'h0000;
            edit_rejected <= 1'b0;
        end
        else
        begin
            edit_rejected <= (edit_strobe || init_strobe || limit_strobe) && edit_lock;
            if ((edit_strobe || init_strobe || limit_strobe) && edit_lock)
                lock_cnt_reg <= 15'(SPC_LOCK_TICKS);
            else if (tick_reg && lock_cnt_reg != 15'h0000)
                lock_cnt_reg <= lock_cnt_reg - 15'h0001;
        end
    end

    // ------------------------------------------------------------
    // control tick
    // ------------------------------------------------------------
    // free-running 100 us control tick
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_reg <= 15'h0000;
            tick_reg     <= 1'b0;
        end
        else
        begin
            tick_reg     <= (tick_cnt_reg == 15'(SPC_TICK_CYCLES - 1));
            tick_cnt_reg <= (tick_cnt_reg == 15'(SPC_TICK_CYCLES - 1)) ? 15'h0000
                          : tick_cnt_reg + 15'h0001;
        end
    end

    // ------------------------------------------------------------
    // run state and alarms
    // ------------------------------------------------------------
    spc_state_t  state_reg;
    logic        latched_hard;

    assign latched_hard = (alarm_code == SPC_AL_OVERCUR) || (alarm_code == SPC_AL_STORAGE);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg  <= SPC_ST_IDLE;
            alarm_code <= SPC_AL_NONE;
        end
        else if (alarm_event)
        begin
            state_reg  <= SPC_ST_ALARM;
            alarm_code <= alarm_code_in;
        end
        else
        begin
            unique case (state_reg)
                SPC_ST_IDLE:  if (stop_reg) state_reg <= SPC_ST_ESTOP;
                              else if (run_reg) state_reg <= SPC_ST_RUN;
                SPC_ST_RUN:   if (stop_reg) state_reg <= SPC_ST_ESTOP;
                              else if (!run_reg && speed_ref == 13'h0)
                                  state_reg <= SPC_ST_IDLE;
                SPC_ST_ESTOP: if (!stop_reg && !run_reg) state_reg <= SPC_ST_IDLE;
                SPC_ST_ALARM: if (alarm_reset && !latched_hard)
                              begin
                                  state_reg  <= SPC_ST_IDLE;
                                  alarm_code <= SPC_AL_NONE;
                              end
            endcase
        end
    end

    // ------------------------------------------------------------
    // speed reference ramp
    // ------------------------------------------------------------
    logic [12:0] target, step_up, step_dn, span;

    always_comb
    begin
        target  = (state_reg == SPC_ST_RUN && run_reg) ? rd_data[28:16] : 13'h0;
        span    = ramp_digital ? rd_data[28:16] : SPC_SPEED_RATED;
        step_up = ramp_step(span, ramp_digital ? rd_data[15:8] : pot_time);
        step_dn = ramp_step(span, ramp_digital ? rd_data[7:0] : pot_time);
    end

    // linear move per tick; external stops and alarms drop the reference at once
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            speed_ref <= 13'h0;
        else if (state_reg == SPC_ST_ESTOP || state_reg == SPC_ST_ALARM)
            speed_ref <= 13'h0;
        else if (tick_reg && !edit_strobe && !sweep_busy_reg)
        begin
            if (speed_ref < target)
                speed_ref <= (target - speed_ref > step_up) ? speed_ref + step_up : target;
            else if (speed_ref > target)
                speed_ref <= (speed_ref - target > step_dn) ? speed_ref - step_dn : target;
        end
    end

    // ------------------------------------------------------------
    // outputs: drive, hold, displays
    // ------------------------------------------------------------
    logic [11:0] blink_cnt_reg;
    logic        blink_reg;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            drive_enable  <= 1'b0;
            hold_torque   <= 7'h00;
            active_set    <= 2'h0;
            warning_out   <= 1'b0;
            lock_indicate <= 1'b0;
        end
        else
        begin
            active_set    <= {sel1_reg, sel0_reg};
            drive_enable  <= (state_reg == SPC_ST_RUN);
            // warning only while no alarm stands yet
            warning_out   <= warn_level && (state_reg != SPC_ST_ALARM);
            lock_indicate <= (lock_cnt_reg != 15'h0000);
            // proportional hold, capped at half rated; off unless enabled
            if (hold_enable && state_reg == SPC_ST_IDLE && speed_ref == 13'h0)
                hold_torque <= (angle_dev[7:1] > SPC_HOLD_MAX_PCT) ? SPC_HOLD_MAX_PCT
                             : angle_dev[7:1];
            else
                hold_torque <= 7'h00;
        end
    end

    // alarm display: steady on the alarm screen, blinking on others
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            blink_cnt_reg    <= 12'h000;
            blink_reg        <= 1'b0;
            alarm_display_on <= 1'b0;
        end
        else
        begin
            if (tick_reg)
            begin
                blink_cnt_reg <= (blink_cnt_reg == 12'(SPC_BLINK_TICKS - 1)) ? 12'h000
                               : blink_cnt_reg + 12'h001;
                if (blink_cnt_reg == 12'(SPC_BLINK_TICKS - 1))
                    blink_reg <= ~blink_reg;
            end
            alarm_display_on <= (state_reg == SPC_ST_ALARM) && (!other_screen || blink_reg);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_alarm_hit;
        alarm_event;
    endsequence

    sequence s_coasting;
        !drive_enable && speed_ref == 13'h0;
    endsequence

    a_alarm_coast_stop: assert property (@(posedge clock) disable iff (rst)
        s_alarm_hit |-> ##2 s_coasting)
        else $error("alarm did not remove drive");

    a_estop_immediate: assert property (@(posedge clock) disable iff (rst)
        (state_reg == SPC_ST_ESTOP) |=> (speed_ref == 13'h0 && !drive_enable))
        else $error("external stop did not halt at once");

    a_hard_alarm_hold: assert property (@(posedge clock) disable iff (rst)
        (state_reg == SPC_ST_ALARM && latched_hard && alarm_reset) |=> state_reg == SPC_ST_ALARM)
        else $error("hard alarm cleared by reset");

    a_hold_cap: assert property (@(posedge clock) disable iff (rst)
        hold_torque <= SPC_HOLD_MAX_PCT)
        else $error("hold torque above half rated");

    a_hold_off: assert property (@(posedge clock) disable iff (rst)
        !$past(hold_enable) |-> hold_torque == 7'h00)
        else $error("hold torque while disabled");

    a_lock_reject: assert property (@(posedge clock) disable iff (rst)
        (edit_strobe && edit_lock) |-> !wr_en || sweep_valid_reg)
        else $error("write accepted under lock");

    a_lock_show: assert property (@(posedge clock) disable iff (rst)
        (edit_strobe && edit_lock) |-> ##2 lock_indicate)
        else $error("lock indication missing");

    a_speed_window: assert property (@(posedge clock) disable iff (rst)
        (wr_en && !sweep_valid_reg && edit_field == 2'(SPC_FIELD_SPEED) && !init_strobe)
        |-> (wr_data[28:16] <= upper_reg && wr_data[28:16] >= lower_reg))
        else $error("speed outside limits written");

    a_ref_bounded: assert property (@(posedge clock) disable iff (rst)
        speed_ref <= SPC_SPEED_MAX)
        else $error("speed reference above maximum");
endmodule
`default_nettype wire

// [common/spc_pkg.sv]
// package with constants and types of the speed profile control block
package spc_pkg;
    // speed figures in r/min
    localparam logic [12:0] SPC_SPEED_MIN     = 13'd50;
    localparam logic [12:0] SPC_SPEED_MAX     = 13'd4000;
    localparam logic [12:0] SPC_SPEED_RATED   = 13'd3000;
    localparam logic [12:0] SPC_SPEED_DEFAULT = 13'd50;
    // ramp times in tenths of a second
    localparam logic [7:0]  SPC_TIME_MIN      = 8'd1;
    localparam logic [7:0]  SPC_TIME_MAX      = 8'd150;
    localparam logic [7:0]  SPC_TIME_DIG_DEF  = 8'd5;
    localparam logic [7:0]  SPC_TIME_POT_DEF  = 8'd1;
    // timing
    localparam int          SPC_CLOCK_MHZ     = 200;
    localparam int          SPC_TICK_US       = 100;
    localparam int          SPC_TICK_CYCLES   = SPC_TICK_US * SPC_CLOCK_MHZ;
    localparam int          SPC_LOCK_MS       = 1000;
    localparam int          SPC_LOCK_TICKS    = SPC_LOCK_MS * 1000 / SPC_TICK_US;
    localparam int          SPC_BLINK_TICKS   = 2500;
    // ticks per tenth of a second
    localparam int          SPC_TICKS_PER_DS  = 100000 / SPC_TICK_US;
    // holding torque: percent of rated at full deviation
    localparam logic [6:0]  SPC_HOLD_MAX_PCT  = 7'd50;
    // alarm codes
    localparam logic [7:0]  SPC_AL_NONE       = 8'h00;
    localparam logic [7:0]  SPC_AL_OVERCUR    = 8'h20;
    localparam logic [7:0]  SPC_AL_STORAGE    = 8'h41;
    // number of operation data sets
    localparam int          SPC_SETS          = 4;

    typedef enum logic [1:0] {SPC_FIELD_SPEED, SPC_FIELD_ACC, SPC_FIELD_DEC} spc_field_t;
    typedef enum {SPC_ST_IDLE, SPC_ST_RUN, SPC_ST_ESTOP, SPC_ST_ALARM} spc_state_t;
endpackage

// [design/spc_data_mem.sv]
// four-entry operation data memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module spc_data_mem
    import spc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // write port
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_idx,
    input  wire logic [28:0] wr_data,
    // read port
    input  wire logic [1:0]  rd_idx,
    output var  logic [28:0] rd_data
);
    logic [28:0] mem_reg [SPC_SETS];

    // storage, factory defaults after reset
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < SPC_SETS; i++)
                mem_reg[i] <= {SPC_SPEED_DEFAULT, SPC_TIME_DIG_DEF, SPC_TIME_DIG_DEF};
        end
        else if (wr_en)
            mem_reg[wr_idx] <= wr_data;
    end

    // registered read, one cycle of latency
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rd_data <= {SPC_SPEED_DEFAULT, SPC_TIME_DIG_DEF, SPC_TIME_DIG_DEF};
        else
            rd_data <= mem_reg[rd_idx];
    end
endmodule
`default_nettype wire

// [tb/spc_plc_model.sv]
// pin-level model of the controller that drives the select, run and stop inputs
`timescale 1ns/1ps
`default_nettype none
module spc_plc_model
(
    // commanded levels from the bench
    input  wire logic [1:0] sel_cmd,
    input  wire logic       run_cmd,
    input  wire logic       stop_cmd,
    // driver input pins
    output wire logic       data_select_bit0,
    output wire logic       data_select_bit1,
    output wire logic       run_in,
    output wire logic       ext_stop_in
);
    // output stage lag: pins follow commands 2 ns late, never on a clock edge
    assign #2 data_select_bit0 = sel_cmd[0];
    assign #2 data_select_bit1 = sel_cmd[1];
    assign #2 run_in           = run_cmd;
    assign #2 ext_stop_in      = stop_cmd;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench of the speed profile control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import spc_pkg::*;
    logic clock = 1'b0, rst = 1'b1, run_cmd = 1'b0, stop_cmd = 1'b0;
    logic [1:0] sel_cmd = 2'h0, edit_field = 2'h0, edit_set = 2'h0;
    logic edit_strobe = 1'b0, init_strobe = 1'b0, edit_lock = 1'b0, ramp_digital = 1'b0;
    logic limit_strobe = 1'b0, hold_enable = 1'b0, alarm_event = 1'b0, warn_level = 1'b0;
    logic alarm_reset = 1'b0, other_screen = 1'b0, seen;
    logic [12:0] edit_value = 13'h0, limit_upper = 13'hFA0, limit_lower = 13'h032;
    logic [7:0] pot_time = 8'h01, angle_dev = 8'h00, alarm_code_in = 8'h00;
    wire logic data_select_bit0, data_select_bit1, run_in, ext_stop_in;
    logic [12:0] speed_ref;
    logic drive_enable, alarm_display_on, warning_out, lock_indicate, edit_rejected;
    logic [6:0] hold_torque;
    logic [7:0] alarm_code;
    logic [1:0] active_set;
    int num_errors = 0, n_compared = 0, exp_ref = 0;

    spc_plc_model spc_plc_model_i (.sel_cmd, .run_cmd, .stop_cmd, .data_select_bit0,
        .data_select_bit1, .run_in, .ext_stop_in);
    spc_speed_profile spc_speed_profile_i (.clock, .rst, .data_select_bit0, .data_select_bit1,
        .run_in, .ext_stop_in, .edit_strobe, .edit_field, .edit_set, .edit_value,
        .init_strobe, .edit_lock, .ramp_digital, .pot_time, .limit_strobe, .limit_upper,
        .limit_lower, .hold_enable, .angle_dev, .alarm_event, .alarm_code_in, .warn_level,
        .alarm_reset, .other_screen, .speed_ref, .drive_enable, .hold_torque, .alarm_code,
        .alarm_display_on, .warning_out, .lock_indicate, .edit_rejected, .active_set);

    // 200 MHz clock
    initial
    begin
        forever #2.5 clock = ~clock;
    end

    // wait n rising edges, then step just past the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // wait until the speed reference moves, bounded by one tick and a margin
    task automatic wait_ramp;
        logic [12:0] v;
        v = speed_ref;
        for (int i = 0; i <= SPC_TICK_CYCLES + 20 && speed_ref == v; i++)
            step(1);
    endtask

    // dial edit held two cycles, the second write counts; one idle cycle after
    task automatic edit(input logic [1:0] field, input logic [12:0] value);
        edit_field = field;
        edit_value = value;
        edit_strobe = 1'b1;
        step(2);
        edit_strobe = 1'b0;
        step(1);
    endtask

    // one comparison, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // holding torque grows with deviation, clipped at half of rated
    function automatic logic [6:0] exp_hold(input logic [7:0] a);
        return ((a >> 1) > SPC_HOLD_MAX_PCT) ? SPC_HOLD_MAX_PCT : 7'(a >> 1);
    endfunction

    // ramp step per tick: span covered in t tenths of a second, at least 1 r/min
    function automatic int exp_step(input int span, input int t);
        return (span < t * SPC_TICKS_PER_DS) ? 1 : span / (t * SPC_TICKS_PER_DS);
    endfunction

    // counts and verdict
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // watchdog: the run needs about three ramp ticks of 5 ns cycles, allow four
    initial
    begin
        #(4 * SPC_TICK_CYCLES * 5);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(13));
        step(6);
        rst = 1'b0;
        step(1);
        chk(drive_enable, 1'b0);
        chk(hold_torque, 7'h00);
        $display("test reset done");
        // select pins choose the active set
        for (int i = 0; i < 8; i++)
        begin
            sel_cmd = 2'($urandom);
            step(8);
            chk(active_set, sel_cmd);
        end
        $display("test select done");
        // holding torque only when enabled, boundary deviations included
        angle_dev = 8'hFF;
        step(4);
        chk(hold_torque, 7'h00);
        hold_enable = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            angle_dev = (i == 0) ? 8'h64 : (i == 1) ? 8'h65 : 8'($urandom);
            step(4);
            chk(hold_torque, exp_hold(angle_dev));
        end
        warn_level = 1'b1;
        step(4);
        chk(warning_out, 1'b1);
        warn_level = 1'b0;
        $display("test hold and warning done");
        // unlocked init, edits and limit load pass; limits overwrite and refuse speeds
        edit_set = sel_cmd;
        init_strobe = 1'b1;
        step(1);
        init_strobe = 1'b0;
        chk(edit_rejected, 1'b0);
        edit(2'(SPC_FIELD_SPEED), 13'd4000);
        edit(2'(SPC_FIELD_ACC), 13'd1);
        limit_upper = 13'd2000;
        limit_strobe = 1'b1;
        step(1);
        limit_strobe = 1'b0;
        chk(edit_rejected, 1'b0);
        step(8);
        edit(2'(SPC_FIELD_SPEED), 13'd4000);
        edit(2'(SPC_FIELD_SPEED), 13'd40);
        edit_lock = 1'b1;
        edit_strobe = 1'b1;
        step(2);
        edit_strobe = 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            seen = seen | edit_rejected;
            step(1);
        end
        chk(seen, 1'b1);
        chk(lock_indicate, 1'b1);
        edit_lock = 1'b0;
        $display("test lock done");
        // first tick on the shortest pot ramp, then the digital ramp, then init mid-run
        hold_enable = 1'b1;
        angle_dev = 8'h40;
        run_cmd = 1'b1;
        wait_ramp();
        exp_ref = exp_step(SPC_SPEED_RATED, pot_time);
        chk(speed_ref, 16'(exp_ref));
        chk(drive_enable, 1'b1);
        ramp_digital = 1'b1;
        wait_ramp();
        exp_ref += exp_step(2000, 1);
        chk(speed_ref, 16'(exp_ref));
        init_strobe = 1'b1;
        step(1);
        init_strobe = 1'b0;
        wait_ramp();
        exp_ref += exp_step(SPC_SPEED_DEFAULT, SPC_TIME_DIG_DEF);
        chk(speed_ref, 16'(exp_ref));
        // external stop halts at once and leaves no hold
        stop_cmd = 1'b1;
        step(6);
        chk(speed_ref, 13'h0);
        chk(drive_enable, 1'b0);
        chk(hold_torque, 7'h00);
        stop_cmd = 1'b0;
        run_cmd = 1'b0;
        step(8);
        chk(hold_torque, exp_hold(angle_dev));
        $display("test stop done");
        // soft alarm shows, coasts and clears; storage alarm ignores reset
        hold_enable = 1'b1;
        other_screen = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            alarm_code_in = (k == 0) ? 8'h30 : SPC_AL_STORAGE;
            alarm_event = 1'b1;
            step(1);
            alarm_event = 1'b0;
            step(4);
            chk(alarm_code, alarm_code_in);
            chk(drive_enable, 1'b0);
            chk(hold_torque, 7'h00);
            chk(alarm_display_on, 1'b1);
            alarm_reset = 1'b1;
            step(1);
            alarm_reset = 1'b0;
            step(4);
            chk(alarm_code, (k == 0) ? SPC_AL_NONE : SPC_AL_STORAGE);
            chk(alarm_display_on, k == 1);
        end
        $display("test alarm done");
        wrap_up();
    end
endmodule
`default_nettype wire
